// ### design/amf_dev.sv
`timescale 1ns/1ps
// How it works
// - answer slave byte 50H when select low
// - answer slave byte 52H when select high
// - fet bits drive fets, read back
// - fet writes ignored unless override set
// - precharge replaces charge when cell low
// - charge fet on in ov if discharging
// - discharge fet on in uv if charging
// - memory bit selects eeprom, else ram
// - status register shows faults and conditions
// - host writes mux select at 0x85
// - mux field drives mux stages directly
// - scan every 32/256/512 ms by mode
module amf_dev #(
   parameter int SCAN_NRM = amf_pkg::SCAN_NRM_CYC,
   parameter int SCAN_IDL = amf_pkg::SCAN_IDL_CYC,
   parameter int SCAN_DOZ = amf_pkg::SCAN_DOZ_CYC
) (
   input  wire logic   clk,
   input  wire logic   rst,
   amf_lnk_if.dev      lnk,
   input  wire logic   addr_sel_pin,
   input  wire logic [7:0] flag_pins,
   input  wire logic   adc_done,
   input  wire logic [11:0] adc_result,
   output logic        precharge_fet_on,
   output logic        charge_fet_on,
   output logic        discharge_fet_on,
   output logic [3:0]  mux_sel,
   output logic [1:0]  gain_sel,
   output logic        adc_start,
   output logic        eeprom_sel,
   output logic        scan_start
);
   import amf_pkg::*;

   // 24-bit counter; below two the scan pulse never drops
   if (SCAN_NRM < 2 || SCAN_NRM >= (1 << 24)) begin : g_bad_nrm
      $error("amf_dev: normal scan period out of range");
   end
   if (SCAN_IDL < 2 || SCAN_IDL >= (1 << 24)) begin : g_bad_idl
      $error("amf_dev: idle scan period out of range");
   end
   if (SCAN_DOZ < 2 || SCAN_DOZ >= (1 << 24)) begin : g_bad_doz
      $error("amf_dev: doze scan period out of range");
   end

   typedef struct packed {
      logic        asel_m;
      logic        asel;
      logic [7:0]  flg_m;
      logic [7:0]  flg;
      logic [7:0]  fet;
      logic [7:0]  mux;
      logic [11:0] res;
      logic        ack;
      logic        nak;
      logic [7:0]  rdata;
      logic        start;
      logic [23:0] cnt;
      logic        scan;
   } amf_dev_st_t;

   amf_dev_st_t s_q, s_d;
   logic        hit;
   logic        auto_c, auto_d, auto_p;
   logic [23:0] period;

   always_comb begin
      s_d = s_q;
      // pins pass two flops before use
      s_d.asel_m = addr_sel_pin;
      s_d.asel   = s_q.asel_m;
      s_d.flg_m  = flag_pins;
      s_d.flg    = s_q.flg_m;
      s_d.ack    = 1'b0;
      s_d.nak    = 1'b0;
      s_d.start  = 1'b0;
      s_d.scan   = 1'b0;

      // high address
      // direction bit ignored here, it only picks read or write
      if (s_q.asel) begin
         hit = lnk.slave_byte[7:1] == SLV_BYTE_HI[7:1];
      end else begin
         hit = lnk.slave_byte[7:1] == SLV_BYTE_LO[7:1];
      end

      auto_c = !s_q.flg[ST_OV] ||
               (s_q.fet[FET_C_OV] && s_q.flg[ST_DCHG]);
      auto_d = !s_q.flg[ST_UV] ||
               (s_q.fet[FET_D_UV] && s_q.flg[ST_CHG]);
      auto_p = auto_c && s_q.fet[FET_PC_EN] && s_q.flg[ST_CLOW];
      // stand-alone: bits track the automatic decision for readback
      if (!s_q.fet[FET_OVR]) begin
         s_d.fet[FET_PRE] = auto_p;
         // charge gate stays off while precharge runs
         s_d.fet[FET_CHG] = auto_c && !auto_p;
         s_d.fet[FET_DIS] = auto_d;
      end

      // start bit stays set until the result lands
      // capture result, clear start
      if (adc_done && s_q.mux[CONV_START]) begin
         s_d.res             = adc_result;
         s_d.mux[CONV_START] = 1'b0;
      end

      // one request per handshake; host drops req after the answer
      if (lnk.req && !s_q.ack && !s_q.nak) begin
         // foreign slave byte: refused, nothing changes
         if (!hit) begin
            s_d.nak = 1'b1;
         end else if (lnk.slave_byte[0]) begin
            s_d.ack = 1'b1;
            case (lnk.reg_adr)
               REG_STATUS:  s_d.rdata = s_q.flg;
               REG_FET_CTL: s_d.rdata = s_q.fet;
               REG_MUX_CTL: s_d.rdata = s_q.mux;
               REG_RES_LO:  s_d.rdata = s_q.res[7:0];
               REG_RES_HI:  s_d.rdata = {4'h0, s_q.res[11:8]};
               default:     s_d.rdata = 8'h00;
            endcase
         end else begin
            s_d.ack = 1'b1;
            case (lnk.reg_adr)
               REG_FET_CTL: begin
                  s_d.fet[FET_EEPROM] = lnk.wdata[FET_EEPROM];
                  // clearing override hands fets back to the policy
                  s_d.fet[FET_OVR]    = lnk.wdata[FET_OVR];
                  s_d.fet[FET_PC_EN]  = lnk.wdata[FET_PC_EN];
                  s_d.fet[FET_C_OV]   = lnk.wdata[FET_C_OV];
                  s_d.fet[FET_D_UV]   = lnk.wdata[FET_D_UV];
                  if (s_q.fet[FET_OVR]) begin
                     s_d.fet[FET_PRE] = lnk.wdata[FET_PRE];
                     s_d.fet[FET_CHG] = lnk.wdata[FET_CHG];
                     s_d.fet[FET_DIS] = lnk.wdata[FET_DIS];
                  end
               end
               REG_MUX_CTL: begin
                  s_d.mux[MUX_SEL_LSB +: 4] = lnk.wdata[MUX_SEL_LSB +: 4];
                  s_d.mux[GAIN_LSB +: 2]    = lnk.wdata[GAIN_LSB +: 2];
                  s_d.mux[CONV_START]       = lnk.wdata[CONV_START];
                  s_d.start                 = lnk.wdata[CONV_START];
               end
               default: ;
            endcase
         end
      end

      case (s_q.flg[ST_PM +: 2])
         PM_NORMAL: period = 24'(SCAN_NRM);
         PM_IDLE:   period = 24'(SCAN_IDL);
         default:   period = 24'(SCAN_DOZ);
      endcase
      // >= so a shorter mode after a change wraps at once
      if (s_q.cnt >= period - 24'h000001) begin
         s_d.cnt = 24'h000000;
         // host conversion holds the scan off
         s_d.scan = !s_q.mux[CONV_START];
      end else begin
         s_d.cnt = s_q.cnt + 24'h000001;
      end
   end

   // all gates off in reset until the policy runs
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q     <= '0;
         s_q.fet <= FET_CTL_RST;
         s_q.mux <= MUX_CTL_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign lnk.ack   = s_q.ack;
   assign lnk.nak   = s_q.nak;
   assign lnk.rdata = s_q.rdata;
   // gate drives straight from flops, no glitches
   // fet outputs
   assign precharge_fet_on = s_q.fet[FET_PRE];
   assign charge_fet_on    = s_q.fet[FET_CHG];
   assign discharge_fet_on = s_q.fet[FET_DIS];
   assign mux_sel  = s_q.mux[MUX_SEL_LSB +: 4];
   assign gain_sel = s_q.mux[GAIN_LSB +: 2];
   assign adc_start  = s_q.start;
   assign eeprom_sel = s_q.fet[FET_EEPROM];
   assign scan_start = s_q.scan;
endmodule

// ### design/amf_pkg.sv
package amf_pkg;
   // slave bytes, read/write bit in bit 0
   localparam logic [7:0] SLV_BYTE_LO = 8'h50;
   localparam logic [7:0] SLV_BYTE_HI = 8'h52;
   // device register map
   localparam logic [7:0] REG_STATUS  = 8'h80;
   localparam logic [7:0] REG_FET_CTL = 8'h81;
   localparam logic [7:0] REG_MUX_CTL = 8'h85;
   localparam logic [7:0] REG_RES_LO  = 8'h8A;
   localparam logic [7:0] REG_RES_HI  = 8'h8B;
   // fet control fields
   localparam int FET_PRE    = 0;
   localparam int FET_CHG    = 1;
   localparam int FET_DIS    = 2;
   localparam int FET_OVR    = 3;
   localparam int FET_PC_EN  = 4;
   localparam int FET_C_OV   = 5;
   localparam int FET_D_UV   = 6;
   localparam int FET_EEPROM = 7;
   localparam logic [7:0] FET_CTL_RST = 8'h00;
   // mux control fields
   localparam int MUX_SEL_LSB  = 0;
   localparam int GAIN_LSB     = 4;
   localparam int CONV_START   = 6;
   localparam logic [7:0] MUX_CTL_RST = 8'h00;
   localparam logic [1:0] GAIN_X50    = 2'h1;
   // status pin flags, index into the synchronised vector
   localparam int ST_DCHG  = 0;
   localparam int ST_CHG   = 1;
   localparam int ST_CLOW  = 2;
   localparam int ST_UV    = 3;
   localparam int ST_OV    = 4;
   localparam int ST_FAULT = 5;
   localparam int ST_PM    = 6;
   localparam logic [1:0] PM_NORMAL = 2'h0;
   localparam logic [1:0] PM_IDLE   = 2'h1;
   // scan timing
   localparam int CLK_HZ      = 25000000;
   localparam int SCAN_NRM_MS = 32;
   localparam int SCAN_IDL_MS = 256;
   localparam int SCAN_DOZ_MS = 512;
   localparam int SCAN_NRM_CYC = SCAN_NRM_MS * (CLK_HZ / 1000);
   localparam int SCAN_IDL_CYC = SCAN_IDL_MS * (CLK_HZ / 1000);
   localparam int SCAN_DOZ_CYC = SCAN_DOZ_MS * (CLK_HZ / 1000);
   // host avalon map, byte addresses
   localparam logic [4:0] HA_CMD    = 5'h00;
   localparam logic [4:0] HA_STAT   = 5'h04;
   localparam logic [4:0] HA_ISTAT  = 5'h08;
   localparam logic [4:0] HA_ICLR   = 5'h0C;
   localparam logic [4:0] HA_IEN    = 5'h10;
   localparam int CMD_RD    = 16;
   localparam int CMD_ASEL  = 17;
   localparam int IRQ_DONE  = 0;
   localparam int IRQ_NAK   = 1;
endpackage

// ### design/amf_lnk_if.sv
`timescale 1ns/1ps
interface amf_lnk_if (
   input wire logic clk,
   input wire logic rst
);
   logic       req;
   logic [7:0] slave_byte;
   logic [7:0] reg_adr;
   logic [7:0] wdata;
   logic       ack;
   logic       nak;
   logic [7:0] rdata;
   modport dev  (input req, slave_byte, reg_adr, wdata,
                 output ack, nak, rdata);
   modport host (output req, slave_byte, reg_adr, wdata,
                 input ack, nak, rdata);
endinterface

// ### design/amf_host.sv
`timescale 1ns/1ps
module amf_host (
   input  wire logic   clk,
   input  wire logic   rst,
   amf_lnk_if.host     lnk,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic        avs_waitrequest,
   output logic        irq
);
   import amf_pkg::*;

   typedef struct packed {
      logic        busy;
      logic        req;
      logic [7:0]  sbyte;
      logic [7:0]  adr;
      logic [7:0]  wdat;
      logic [7:0]  rdat;
      logic        nak;
      logic [1:0]  ists;
      logic [1:0]  ien;
      logic        rd_ok;
      logic [31:0] rdd;
   } amf_host_st_t;

   amf_host_st_t s_q, s_d;
   logic         cmd_wr;
   logic [1:0]   ev;

   // reads wait one cycle so read data come from flops
   assign cmd_wr = avs_write && avs_address == HA_CMD;
   assign avs_waitrequest = (avs_read && !s_q.rd_ok) ||
                            (cmd_wr && s_q.busy);

   always_comb begin
      s_d = s_q;
      s_d.rd_ok = avs_read && !s_q.rd_ok;
      ev = 2'b00;
      if (avs_read && !s_q.rd_ok) begin
         case (avs_address)
            HA_CMD:   s_d.rdd = {14'h0000, s_q.sbyte[0],
                                 s_q.sbyte[1], s_q.wdat, s_q.adr};
            HA_STAT:  s_d.rdd = {22'h000000, s_q.rdat,
                                 s_q.nak, s_q.busy};
            HA_ISTAT: s_d.rdd = {30'h00000000, s_q.ists};
            HA_IEN:   s_d.rdd = {30'h00000000, s_q.ien};
            default:  s_d.rdd = 32'h00000000;
         endcase
      end
      if (cmd_wr && !s_q.busy) begin
         s_d.busy  = 1'b1;
         s_d.req   = 1'b1;
         s_d.adr   = avs_writedata[7:0];
         s_d.wdat  = avs_writedata[15:8];
         s_d.sbyte = (avs_writedata[CMD_ASEL] ? SLV_BYTE_HI
                                              : SLV_BYTE_LO) |
                     {7'h00, avs_writedata[CMD_RD]};
      end
      if (s_q.req && (lnk.ack || lnk.nak)) begin
         s_d.req  = 1'b0;
         s_d.busy = 1'b0;
         s_d.nak  = lnk.nak;
         if (lnk.ack && s_q.sbyte[0])
            s_d.rdat = lnk.rdata;
         ev[IRQ_DONE] = 1'b1;
         ev[IRQ_NAK]  = lnk.nak;
      end
      if (avs_write && avs_address == HA_IEN)
         s_d.ien = avs_writedata[1:0];
      // set wins over clear
      if (avs_write && avs_address == HA_ICLR)
         s_d.ists = s_q.ists & ~avs_writedata[1:0];
      s_d.ists = s_d.ists | ev;
   end

   always_ff @(posedge clk) begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign lnk.req        = s_q.req;
   assign lnk.slave_byte = s_q.sbyte;
   assign lnk.reg_adr    = s_q.adr;
   assign lnk.wdata      = s_q.wdat;
   assign avs_readdata   = s_q.rdd;
   assign irq            = |(s_q.ists & s_q.ien);
endmodule

// ### dv/amf_chk.sv
`timescale 1ns/1ps
module amf_chk (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       req,
   input wire logic [7:0] slave_byte,
   input wire logic [7:0] reg_adr,
   input wire logic [7:0] wdata,
   input wire logic       ack,
   input wire logic       nak,
   input wire logic [7:0] rdata
);
   import amf_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   logic odd;
   // neither strap address matches
   assign odd = slave_byte[7:1] != SLV_BYTE_LO[7:1] &&
                slave_byte[7:1] != SLV_BYTE_HI[7:1];
   AST_ANSWER: assert property ($rose(req) |=> ack ^ nak)
      else $error("request not answered in one cycle");
   AST_ONE_ANS: assert property (!(ack && nak))
      else $error("ack and nak together");
   AST_WRONG: assert property ($rose(req) && odd |=> nak)
      else $error("foreign slave byte not refused");
   AST_ACK_OK: assert property (ack |-> !odd)
      else $error("ack for foreign slave byte");
   AST_PULSE: assert property (ack || nak |=> !ack && !nak)
      else $error("answer longer than one cycle");
   AST_HOLD: assert property (req && !ack && !nak |=>
      req && $stable(slave_byte) && $stable(reg_adr) && $stable(wdata))
      else $error("request changed before answer");
   AST_DROP: assert property (ack || nak |=> !req)
      else $error("request kept after answer");
   AST_SPURIOUS: assert property (ack || nak |-> $past(req))
      else $error("answer without request");
   // read data moves only with a read answer
   AST_RDATA: assert property ($changed(rdata) |-> ack && slave_byte[0])
      else $error("read data changed outside read");
   cover property (ack && slave_byte[0]);
   cover property (ack && reg_adr == REG_MUX_CTL && wdata[CONV_START]);
   cover property (nak);
endmodule

// ### dv/adc_mux_fet_override_test.sv
`timescale 1ns/1ps
module adc_mux_fet_override_test;
   import amf_pkg::*;
   logic        clk = 0, rst = 1, sel = 0, rd = 0, wr = 0, done = 0;
   logic [7:0]  flg = 0;
   logic [11:0] res = 0;
   logic [4:0]  adr = 0;
   logic [31:0] wd = 0, q, rdv;
   logic        pre, chg, dis, st, ee, sc, irq, wt;
   logic [3:0]  mux;
   logic [1:0]  gn;
   int          miscompares = 0, num_checks = 0, cyc = 0, nst = 0, t;
   // value, expected mux, expected gain
   logic [13:0] rows [4] = '{{8'h00, 4'h0, 2'h0}, {8'h15, 4'h5, 2'h1},
                             {8'h2F, 4'hF, 2'h2}, {8'h3A, 4'hA, 2'h3}};
   int          per [3] = '{8, 16, 32};
   amf_lnk_if lnk (.clk(clk), .rst(rst));
   // short scan periods keep the run brief
   amf_dev #(.SCAN_NRM(8), .SCAN_IDL(16), .SCAN_DOZ(32)) amf_dev_i (
      .clk(clk), .rst(rst), .lnk(lnk), .addr_sel_pin(sel),
      .flag_pins(flg), .adc_done(done), .adc_result(res),
      .precharge_fet_on(pre), .charge_fet_on(chg),
      .discharge_fet_on(dis), .mux_sel(mux), .gain_sel(gn),
      .adc_start(st), .eeprom_sel(ee), .scan_start(sc));
   amf_host amf_host_i (.clk(clk), .rst(rst), .lnk(lnk),
      .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_readdata(rdv),
      .avs_waitrequest(wt), .irq(irq));
   amf_chk amf_chk_i (.clk(clk), .rst(rst), .req(lnk.req),
      .slave_byte(lnk.slave_byte), .reg_adr(lnk.reg_adr),
      .wdata(lnk.wdata), .ack(lnk.ack), .nak(lnk.nak),
      .rdata(lnk.rdata));
   initial begin
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (st === 1'b1) nst++;
      if (cyc == 20000) begin
         miscompares++;
         stop_test;
      end
   end
   task automatic chk(string n, logic [31:0] s, e);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic av(logic w, logic [4:0] a, logic [31:0] d);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      do @(posedge clk); while (wt !== 1'b0);
      q = rdv;
      rd <= 0;
      wr <= 0;
      @(posedge clk);
   endtask
   // one link transfer, status left in q
   task automatic op(logic [7:0] a, d, logic r, s);
      av(1, HA_CMD, {14'h0, s, r, d, a});
      repeat (50) begin
         av(0, HA_STAT, 0);
         if (q[0] === 1'b0) break;
      end
      chk("idle", q[0], 0);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      chk("fets", {pre, chg, dis, irq}, 0);
      av(1, HA_IEN, 3);
      for (int i = 0; i < 4; i++) begin
         op(REG_MUX_CTL, rows[i][13:6], 0, sel);
         chk("mux", mux, rows[i][5:2]);
         chk("gain", gn, rows[i][1:0]);
         op(REG_MUX_CTL, 0, 1, sel);
         chk("muxrb", q[9:2], rows[i][13:6]);
      end
      op(REG_MUX_CTL, 8'h51, 0, sel);
      chk("starts", nst, 1);
      op(REG_MUX_CTL, 0, 1, sel);
      chk("pending", q[8], 1);
      res <= 12'hABC;
      done <= 1;
      @(posedge clk);
      done <= 0;
      op(REG_RES_LO, 0, 1, sel);
      chk("reslo", q[9:2], 8'hBC);
      op(REG_RES_HI, 0, 1, sel);
      chk("reshi", q[9:2], 8'h0A);
      op(REG_MUX_CTL, 0, 1, sel);
      chk("selfclr", q[8], 0);
      op(REG_FET_CTL, 8'h0D, 0, sel);
      chk("fetgate", {pre, chg, dis}, 3'b011);
      op(REG_FET_CTL, 8'h0D, 0, sel);
      chk("fetovr", {pre, chg, dis}, 3'b101);
      op(REG_FET_CTL, 0, 1, sel);
      chk("fetrb", q[4:2], 3'b101);
      op(REG_FET_CTL, 8'h80, 0, sel);
      chk("eeprom", ee, 1);
      flg <= 8'h04;
      op(REG_FET_CTL, 8'h17, 0, sel);
      repeat (5) @(posedge clk);
      chk("precharge", {pre, chg, ee}, 3'b100);
      flg <= 8'h11;
      op(REG_FET_CTL, 8'h00, 0, sel);
      repeat (5) @(posedge clk);
      chk("chgoff", chg, 0);
      op(REG_FET_CTL, 8'h20, 0, sel);
      repeat (5) @(posedge clk);
      chk("chgov", chg, 1);
      flg <= 8'h0A;
      op(REG_FET_CTL, 8'h00, 0, sel);
      repeat (5) @(posedge clk);
      chk("disoff", dis, 0);
      op(REG_FET_CTL, 8'h40, 0, sel);
      repeat (5) @(posedge clk);
      chk("disuv", dis, 1);
      flg <= 8'h2B;
      repeat (5) @(posedge clk);
      op(REG_STATUS, 0, 1, sel);
      chk("status", q[9:2], 8'h2B);
      op(REG_MUX_CTL, 0, 1, !sel);
      chk("nak", q[1], 1);
      av(0, HA_ISTAT, 0);
      chk("istat", {q[1:0], irq}, 3'b111);
      av(1, HA_ICLR, 3);
      chk("irqclr", irq, 0);
      av(1, HA_IEN, 0);
      sel <= 1;
      repeat (5) @(posedge clk);
      op(REG_MUX_CTL, 0, 1, 1);
      chk("ackhi", {q[1], irq}, 0);
      av(0, 5'h14, 0);
      chk("unmapped", q, 0);
      av(0, HA_CMD, 0);
      chk("cmdrb", q, 32'h00030085);
      rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      chk("rstmid", {mux, gn, dis, ee, irq}, 0);
      // settle mode, skip one pulse, time the next gap
      for (int m = 0; m < 3; m++) begin
         flg <= {m[1:0], 6'h0};
         repeat (80) @(posedge clk);
         while (sc !== 1'b1) @(posedge clk);
         @(posedge clk);
         t = 1;
         while (sc !== 1'b1) begin
            @(posedge clk);
            t++;
         end
         chk("scan", t, per[m]);
      end
      stop_test;
   end
endmodule
